// File: hw/rdl_lane_regs.sv
// Notes on behaviour
// (RULE1) bit 7 of lane register turns aux snooping off when set.
// (RULE2) route code 00: aux to sideband follows lane config high bit and flip.
// (RULE3) route code 01: positive to pin one, negative to pin two, always.
// (RULE4) route code 10: positive to pin two, negative to pin one, always.
// (RULE5) route code 11: both aux lines disconnected from both sideband pins.
// (RULE6) lane off bits steer lanes only while snooping is off.
// (RULE7) lane off bit 0 means enabled, 1 means disabled, reset enabled.
// (RULE8) with snooping on, lanes follow snooped lane count, others off.
// (RULE9) two four-bit downstream receiver eq selects in bits 7:4 and 3:0.
// (RULE10) without software override eq selects read back straps, else written values.
// (RULE11) upstream eq select in bits 3:0, same override, upper bits reserved.
// (RULE12) read-only bit 7 shows compliance mode active, reset zero.
// (RULE13) low_freq_signal_eq_apply bit 0 forces eq zero during lfps, 1 applies selects.
// (RULE14) debounce bit set: lfps must persist 200us before low-power exit.
// (RULE15) detect off bit set: no receiver detect while in low power.
// (RULE16) detect interval code picks 8, 12, 48 or 96 ms.
// (RULE17) compliance code: fsm, forced downstream, forced upstream, disabled.
// (RULE18) reserved bits read zero, ignore writes; all registers reset to zero.
`timescale 1ns/1ps
`default_nettype none
module rdl_lane_regs
	import rdl_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a,
	parameter int EXIT_DEB_CYC = EXIT_DEBOUNCE_CYC,
	parameter int DET0_CYC = DET_INT0_CYC,
	parameter int DET1_CYC = DET_INT1_CYC,
	parameter int DET2_CYC = DET_INT2_CYC,
	parameter int DET3_CYC = DET_INT3_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// serial management bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// from the general control slice
	input wire logic eq_software_override_i,
	input wire logic lane_config_high_bit_i,
	input wire logic orientation_flip_select_i,
	input wire logic [4:0] snooped_lane_count_i,
	// straps and analog status
	input wire logic [1:0] downstream_eq_straps_i,
	input wire logic [1:0] upstream_eq_straps_i,
	input wire logic lfps_detect_i,
	input wire logic low_power_state_i,
	input wire logic fsm_compliance_i,
	// sideband switches
	output logic aux_p_sb1_o,
	output logic aux_n_sb2_o,
	output logic aux_p_sb2_o,
	output logic aux_n_sb1_o,
	// lanes and equalization
	output logic [3:0] lane_enable_o,
	output logic [3:0] rx_one_eq_o,
	output logic [3:0] rx_two_eq_o,
	output logic [3:0] upstream_eq_o,
	// low power and compliance
	output logic low_power_exit_o,
	output logic rx_detect_pulse_o,
	output logic compliance_force_down_o,
	output logic compliance_force_up_o,
	output logic compliance_active_flag_o
);
	typedef struct packed {
		rdl_bus_st_t bus_st;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic drive;
		logic rw;
		logic more;
		logic [7:0] ptr;
		logic scl_p;
		logic sda_p;
		logic snoop_off;
		logic [1:0] route;
		logic [3:0] lane_off;
		logic [3:0] eq_two_sw;
		logic [3:0] eq_one_sw;
		logic [3:0] up_sw;
		logic lfps_apply;
		logic deb_on;
		logic rxdet_off;
		logic [1:0] interval;
		logic [1:0] cctrl;
		logic [1:0] strap_wait;
		logic [1:0] strap_dn;
		logic [1:0] strap_up;
		logic [3:0] sw;
		logic [3:0] lane_en;
		logic [3:0] eq_one;
		logic [3:0] eq_two;
		logic [3:0] eq_up;
		logic compliance_active_flag;
		logic force_dn;
		logic force_up;
		logic [CNT_W-1:0] deb_cnt;
		logic exit_ok;
		logic [CNT_W-1:0] det_cnt;
		logic det_pulse;
	} rdl_regs_state_t;

	localparam logic [CNT_W-1:0] DEB_LIM = CNT_W'(EXIT_DEB_CYC - 1);

	rdl_regs_state_t st_q;
	rdl_regs_state_t st_d;
	logic scl_s, sda_s, lfps_s, lp_s, fsm_s;
	logic [1:0] dn_s, up_s;
	logic [SYNC_W-1:0] sync_out;
	logic [3:0] sel_one, sel_two, sel_up, snoop_mask;
	logic [7:0] rd_data;

	// bus, strap and analog status pins pass two flops; control slice inputs do not
	rdl_sync #(.W(SYNC_W)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({scl_i, sda_i, downstream_eq_straps_i, upstream_eq_straps_i,
			lfps_detect_i, low_power_state_i, fsm_compliance_i}),
		.sync_o(sync_out)
	);
	assign {scl_s, sda_s, dn_s, up_s, lfps_s, lp_s, fsm_s} = sync_out;

	// effective eq selects: straps or software
	assign sel_one = eq_software_override_i ? st_q.eq_one_sw : 4'(st_q.strap_dn); // RULE10
	assign sel_two = eq_software_override_i ? st_q.eq_two_sw : 4'(st_q.strap_dn); // RULE9
	assign sel_up = eq_software_override_i ? st_q.up_sw : 4'(st_q.strap_up); // RULE11
	// lanes named by the snooped count
	assign snoop_mask = (snooped_lane_count_i > LANE_MAX) ? LANE_ALL :
		~(LANE_ALL << snooped_lane_count_i); // RULE8

	// register read mux, reserved bits zero
	always_comb begin
		case (st_q.ptr)
			REG_DISP_AUX: rd_data = {st_q.snoop_off, 1'b0, st_q.route, st_q.lane_off}; // RULE18
			REG_DN_EQ: rd_data = {sel_two, sel_one}; // RULE9
			REG_UP_EQ: rd_data = {4'h0, sel_up}; // RULE11
			REG_PWR_CM: rd_data = {st_q.compliance_active_flag, st_q.lfps_apply, st_q.deb_on, st_q.rxdet_off,
				st_q.interval, st_q.cctrl}; // RULE12
			default: rd_data = REG_UNMAPPED;
		endcase
	end

	// next state of bus slave, registers and control
	always_comb begin
		logic rise, fall, start, stop, wr_en, in_lp;
		logic [CNT_W-1:0] det_lim;
		rise = 1'b0;
		fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		wr_en = 1'b0;
		in_lp = 1'b0;
		det_lim = '0;
		st_d = st_q;
		rise = scl_s & ~st_q.scl_p;
		fall = ~scl_s & st_q.scl_p;
		start = scl_s & st_q.scl_p & st_q.sda_p & ~sda_s;
		stop = scl_s & st_q.scl_p & ~st_q.sda_p & sda_s;
		st_d.scl_p = scl_s;
		st_d.sda_p = sda_s;
		// serial byte engine
		if (start) begin
			st_d.bus_st = RDL_ADDR;
			st_d.cnt = '0;
			st_d.drive = 1'b0;
		end else if (stop) begin
			st_d.bus_st = RDL_IDLE;
			st_d.drive = 1'b0;
		end else begin
			case (st_q.bus_st)
				RDL_ADDR, RDL_PTR, RDL_WDATA: begin
					if (rise) begin
						st_d.shift = {st_q.shift[6:0], sda_s};
						st_d.cnt = st_q.cnt + 4'h1;
					end else if (fall && st_q.cnt == BYTE_BITS) begin
						st_d.cnt = '0;
						if (st_q.bus_st == RDL_ADDR) begin
							if (st_q.shift[7:1] == DEV_ADDR) begin
								st_d.drive = 1'b1;
								st_d.rw = st_q.shift[0];
								st_d.bus_st = RDL_ADDR_ACK;
							end else begin
								st_d.bus_st = RDL_IGNORE;
							end
						end else if (st_q.bus_st == RDL_PTR) begin
							st_d.ptr = st_q.shift;
							st_d.drive = 1'b1;
							st_d.bus_st = RDL_PTR_ACK;
						end else begin
							wr_en = 1'b1;
							st_d.ptr = st_q.ptr + 8'h01;
							st_d.drive = 1'b1;
							st_d.bus_st = RDL_WDATA_ACK;
						end
					end
				end
				RDL_ADDR_ACK, RDL_PTR_ACK, RDL_WDATA_ACK: begin
					if (fall) begin
						st_d.drive = 1'b0;
						if (st_q.bus_st == RDL_ADDR_ACK && st_q.rw) begin
							st_d.shift = rd_data;
							st_d.drive = ~rd_data[7];
							st_d.cnt = '0;
							st_d.bus_st = RDL_RDATA;
						end else if (st_q.bus_st == RDL_ADDR_ACK) begin
							st_d.bus_st = RDL_PTR;
						end else begin
							st_d.bus_st = RDL_WDATA;
						end
					end
				end
				RDL_RDATA: begin
					if (rise) begin
						st_d.cnt = st_q.cnt + 4'h1;
					end else if (fall && st_q.cnt == BYTE_BITS) begin
						st_d.drive = 1'b0;
						st_d.cnt = '0;
						st_d.ptr = st_q.ptr + 8'h01;
						st_d.bus_st = RDL_RACK;
					end else if (fall) begin
						st_d.shift = {st_q.shift[6:0], 1'b0};
						st_d.drive = ~st_q.shift[6];
					end
				end
				RDL_RACK: begin
					if (rise) begin
						st_d.more = ~sda_s;
					end else if (fall && st_q.more) begin
						st_d.shift = rd_data;
						st_d.drive = ~rd_data[7];
						st_d.bus_st = RDL_RDATA;
					end else if (fall) begin
						st_d.bus_st = RDL_IGNORE;
					end
				end
				default: begin
				end
			endcase
		end
		// register writes, reserved and read-only bits dropped
		if (wr_en) begin
			case (st_q.ptr)
				REG_DISP_AUX: begin
					st_d.snoop_off = st_q.shift[SNOOP_OFF_BIT]; // RULE1
					st_d.route = st_q.shift[ROUTE_HI:ROUTE_LO];
					st_d.lane_off = st_q.shift[LANE_OFF_HI:LANE_OFF_LO]; // RULE7
				end
				REG_DN_EQ: begin
					st_d.eq_two_sw = st_q.shift[EQ_HI_MSB:EQ_HI_LSB]; // RULE9
					st_d.eq_one_sw = st_q.shift[EQ_LO_MSB:EQ_LO_LSB];
				end
				REG_UP_EQ: st_d.up_sw = st_q.shift[EQ_LO_MSB:EQ_LO_LSB]; // RULE11
				REG_PWR_CM: begin
					st_d.lfps_apply = st_q.shift[LFPS_APPLY_BIT];
					st_d.deb_on = st_q.shift[EXIT_DEB_BIT];
					st_d.rxdet_off = st_q.shift[RXDET_OFF_BIT];
					st_d.interval = st_q.shift[INTERVAL_HI:INTERVAL_LO];
					st_d.cctrl = st_q.shift[CCTRL_HI:CCTRL_LO];
				end
				default: begin
				end
			endcase
		end
		// straps caught once, after the synchroniser has filled
		if (st_q.strap_wait != STRAP_DONE) begin
			st_d.strap_wait = st_q.strap_wait + 2'h1;
		end
		if (st_q.strap_wait == STRAP_TAKE) begin
			st_d.strap_dn = dn_s;
			st_d.strap_up = up_s;
		end
		// aux to sideband switching
		case (st_q.route)
			ROUTE_AUTO: st_d.sw = !lane_config_high_bit_i ? SW_OPEN :
				(orientation_flip_select_i ? SW_CROSSED : SW_STRAIGHT); // RULE2
			ROUTE_STRAIGHT: st_d.sw = SW_STRAIGHT; // RULE3
			ROUTE_CROSSED: st_d.sw = SW_CROSSED; // RULE4
			default: st_d.sw = SW_OPEN; // RULE5
		endcase
		// lane enables
		st_d.lane_en = st_q.snoop_off ? ~st_q.lane_off : snoop_mask; // RULE6
		// eq forced to zero during lfps unless applied
		if (lfps_s && !st_q.lfps_apply) begin
			st_d.eq_one = '0; // RULE13
			st_d.eq_two = '0;
			st_d.eq_up = '0;
		end else begin
			st_d.eq_one = sel_one;
			st_d.eq_two = sel_two;
			st_d.eq_up = sel_up;
		end
		// compliance mode
		case (st_q.cctrl)
			CM_BY_FSM: st_d.compliance_active_flag = fsm_s; // RULE17
			CM_OFF: st_d.compliance_active_flag = 1'b0;
			default: st_d.compliance_active_flag = 1'b1;
		endcase
		st_d.force_dn = (st_q.cctrl == CM_FORCE_DN);
		st_d.force_up = (st_q.cctrl == CM_FORCE_UP);
		// low-power exit debounce
		in_lp = lp_s & lfps_s;
		if (!in_lp) begin
			st_d.deb_cnt = '0;
		end else if (st_q.deb_cnt != DEB_LIM) begin
			st_d.deb_cnt = st_q.deb_cnt + 1'b1;
		end
		st_d.exit_ok = in_lp & (!st_q.deb_on | st_q.deb_cnt == DEB_LIM); // RULE14
		// receiver detect repeat timer
		case (st_q.interval)
			2'h0: det_lim = CNT_W'(DET0_CYC - 1); // RULE16
			2'h1: det_lim = CNT_W'(DET1_CYC - 1);
			2'h2: det_lim = CNT_W'(DET2_CYC - 1);
			default: det_lim = CNT_W'(DET3_CYC - 1);
		endcase
		if (st_q.det_cnt >= det_lim) begin
			st_d.det_cnt = '0;
			st_d.det_pulse = !(lp_s && st_q.rxdet_off); // RULE15
		end else begin
			st_d.det_cnt = st_q.det_cnt + 1'b1;
			st_d.det_pulse = 1'b0;
		end
	end

	// state register, all zero at reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0; // RULE18
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from state, except sda_o tied to SDA_LOW
	assign sda_o = SDA_LOW;
	assign sda_oe_o = st_q.drive;
	assign {aux_p_sb1_o, aux_n_sb2_o, aux_p_sb2_o, aux_n_sb1_o} = st_q.sw;
	assign lane_enable_o = st_q.lane_en;
	assign rx_one_eq_o = st_q.eq_one;
	assign rx_two_eq_o = st_q.eq_two;
	assign upstream_eq_o = st_q.eq_up;
	assign low_power_exit_o = st_q.exit_ok;
	assign rx_detect_pulse_o = st_q.det_pulse;
	assign compliance_force_down_o = st_q.force_dn;
	assign compliance_force_up_o = st_q.force_up;
	assign compliance_active_flag_o = st_q.compliance_active_flag;

	// checks on the control outputs
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence lp_lfps_fresh_s;
		st_q.deb_on && lp_s && lfps_s && st_q.deb_cnt == '0;
	endsequence
	sequence exit_held_off_s;
		!low_power_exit_o [*8];
	endsequence

	route_auto_a: assert property (st_q.route == ROUTE_AUTO && lane_config_high_bit_i |=> // RULE2
		st_q.sw == ($past(orientation_flip_select_i) ? SW_CROSSED : SW_STRAIGHT))
		else $error("auto sideband routing wrong");
	route_fixed_a: assert property (st_q.route == ROUTE_STRAIGHT |=> // RULE3
		aux_p_sb1_o && aux_n_sb2_o && !aux_p_sb2_o && !aux_n_sb1_o)
		else $error("straight sideband routing wrong");
	route_cross_a: assert property (st_q.route == ROUTE_CROSSED |=> // RULE4
		!aux_p_sb1_o && !aux_n_sb2_o && aux_p_sb2_o && aux_n_sb1_o)
		else $error("crossed sideband routing wrong");
	route_open_a: assert property (st_q.route == ROUTE_OPEN |=> st_q.sw == SW_OPEN) // RULE5
		else $error("open sideband routing wrong");
	lane_manual_a: assert property (st_q.snoop_off |=> lane_enable_o == ~$past(st_q.lane_off)) // RULE6
		else $error("manual lane enable wrong");
	lane_snoop_a: assert property (!st_q.snoop_off |=> lane_enable_o == $past(snoop_mask)) // RULE8
		else $error("snooped lane enable wrong");
	eq_strap_a: assert property (!eq_software_override_i && !lfps_s |=> // RULE10
		rx_one_eq_o == 4'($past(st_q.strap_dn)))
		else $error("strap eq not used");
	lfps_zero_a: assert property (lfps_s && !st_q.lfps_apply |=> // RULE13
		rx_one_eq_o == '0 && rx_two_eq_o == '0 && upstream_eq_o == '0)
		else $error("eq not zero during lfps");
	exit_wait_a: assert property (lp_lfps_fresh_s |=> exit_held_off_s) // RULE14
		else $error("low-power exit before debounce");
	exit_nodeb_a: assert property (!st_q.deb_on && lp_s && lfps_s |=> low_power_exit_o) // RULE14
		else $error("low-power exit missing");
	detect_off_a: assert property (lp_s && st_q.rxdet_off && $stable(lp_s) |=> // RULE15
		!rx_detect_pulse_o)
		else $error("detect pulse while disabled in low power");
	det_gap_a: assert property (rx_detect_pulse_o |=> !rx_detect_pulse_o [*7]) // RULE16
		else $error("detect pulses too close");
	cm_flag_a: assert property (st_q.cctrl == CM_OFF ##1 st_q.cctrl == CM_OFF |-> // RULE12
		!compliance_active_flag_o)
		else $error("compliance flag set while disabled");
	cm_force_a: assert property (st_q.cctrl == CM_FORCE_DN |=> // RULE17
		compliance_force_down_o && !compliance_force_up_o && compliance_active_flag_o)
		else $error("forced downstream compliance wrong");
endmodule
`default_nettype wire

// File: hw/rdl_pkg.sv
package rdl_pkg;
	// register offsets on the management bus
	localparam logic [7:0] REG_DISP_AUX = 8'h13;
	localparam logic [7:0] REG_DN_EQ = 8'h20;
	localparam logic [7:0] REG_UP_EQ = 8'h21;
	localparam logic [7:0] REG_PWR_CM = 8'h22;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] REG_UNMAPPED = 8'h00;

	// display / aux register fields
	localparam int SNOOP_OFF_BIT = 7;
	localparam int ROUTE_HI = 5;
	localparam int ROUTE_LO = 4;
	localparam int LANE_OFF_HI = 3;
	localparam int LANE_OFF_LO = 0;

	// equalization register fields
	localparam int EQ_HI_MSB = 7;
	localparam int EQ_HI_LSB = 4;
	localparam int EQ_LO_MSB = 3;
	localparam int EQ_LO_LSB = 0;

	// power / compliance register fields
	localparam int COMPLIANCE_ACTIVE_FLAG_BIT = 7;
	localparam int LFPS_APPLY_BIT = 6;
	localparam int EXIT_DEB_BIT = 5;
	localparam int RXDET_OFF_BIT = 4;
	localparam int INTERVAL_HI = 3;
	localparam int INTERVAL_LO = 2;
	localparam int CCTRL_HI = 1;
	localparam int CCTRL_LO = 0;

	// sideband routing override codes
	localparam logic [1:0] ROUTE_AUTO = 2'h0;
	localparam logic [1:0] ROUTE_STRAIGHT = 2'h1;
	localparam logic [1:0] ROUTE_CROSSED = 2'h2;
	localparam logic [1:0] ROUTE_OPEN = 2'h3;

	// switch patterns {p_sb1, n_sb2, p_sb2, n_sb1}
	localparam logic [3:0] SW_STRAIGHT = 4'hc;
	localparam logic [3:0] SW_CROSSED = 4'h3;
	localparam logic [3:0] SW_OPEN = 4'h0;

	// compliance control codes
	localparam logic [1:0] CM_BY_FSM = 2'h0;
	localparam logic [1:0] CM_FORCE_DN = 2'h1;
	localparam logic [1:0] CM_FORCE_UP = 2'h2;
	localparam logic [1:0] CM_OFF = 2'h3;

	// lane masks
	localparam logic [3:0] LANE_ALL = 4'hf;
	localparam logic [4:0] LANE_MAX = 5'h04;

	// serial bus
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic SDA_LOW = 1'b0;
	localparam logic [1:0] STRAP_TAKE = 2'h2;
	localparam logic [1:0] STRAP_DONE = 2'h3;
	localparam int SYNC_W = 9;

	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int CLK_KHZ = 40000;
	localparam int EXIT_DEBOUNCE_US = 200;
	localparam int EXIT_DEBOUNCE_CYC = (EXIT_DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DET_INT0_MS = 8;
	localparam int DET_INT1_MS = 12;
	localparam int DET_INT2_MS = 48;
	localparam int DET_INT3_MS = 96;
	localparam int DET_INT0_CYC = DET_INT0_MS * CLK_KHZ;
	localparam int DET_INT1_CYC = DET_INT1_MS * CLK_KHZ;
	localparam int DET_INT2_CYC = DET_INT2_MS * CLK_KHZ;
	localparam int DET_INT3_CYC = DET_INT3_MS * CLK_KHZ;
	localparam int CNT_W = 22;

	// serial bus slave states
	typedef enum logic [3:0] {
		RDL_IDLE,
		RDL_ADDR,
		RDL_ADDR_ACK,
		RDL_PTR,
		RDL_PTR_ACK,
		RDL_WDATA,
		RDL_WDATA_ACK,
		RDL_RDATA,
		RDL_RACK,
		RDL_IGNORE
	} rdl_bus_st_t;
endpackage

// File: hw/rdl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rdl_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// asynchronous in, synchronous out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rdl_sync_state_t;

	rdl_sync_state_t st_q;
	rdl_sync_state_t st_d;

	// first stage feeds only the second
	always_comb begin
		st_d = st_q;
		st_d.s1 = async_i;
		st_d.s2 = st_q.s1;
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_o = st_q.s2;
endmodule
`default_nettype wire

// File: tb/rdl_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module rdl_bus_master #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	// clock
	input wire logic ref_clk_i,
	// bus pins, open drain data
	output logic scl_o,
	output logic sda_oe_o,
	input wire logic sda_i
);
	int nack_count = 0;

	// bus idles released, clock high
	initial begin
		scl_o <= 1'b1;
		sda_oe_o <= 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// one bit: 200 ns period, data moved one clock after the fall
	task automatic put_bit(input logic b, output logic s);
		scl_o <= 1'b0;
		tick(1);
		sda_oe_o <= ~b;
		tick(3);
		scl_o <= 1'b1;
		tick(2);
		s = sda_i;
		tick(2);
	endtask

	task automatic start();
		sda_oe_o <= 1'b1;
		tick(4);
	endtask

	// data released before the clock rises again
	task automatic rstart();
		scl_o <= 1'b0;
		tick(1);
		sda_oe_o <= 1'b0;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_oe_o <= 1'b1;
		tick(4);
	endtask

	task automatic stop();
		scl_o <= 1'b0;
		tick(1);
		sda_oe_o <= 1'b1;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_oe_o <= 1'b0;
		tick(8);
	endtask

	// byte out msb first, then the slave acknowledge
	task automatic put_byte(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], s);
		end
		put_bit(1'b1, s);
		if (s !== 1'b0) nack_count++;
	endtask

	// byte in, last byte answered with no acknowledge
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			d[i] = s;
		end
		put_bit(last, s);
	endtask

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start();
		put_byte({DEV_ADDR, 1'b0});
		put_byte(a);
		put_byte(d);
		stop();
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		start();
		put_byte({DEV_ADDR, 1'b0});
		put_byte(a);
		rstart();
		put_byte({DEV_ADDR, 1'b1});
		get_byte(1'b1, d);
		stop();
	endtask
endmodule
`default_nettype wire

// File: tb/tb_redriver_lane_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_redriver_lane_control_regs
	import rdl_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, m_oe, sda_oe, sda_o, sda;
	logic eq_ovr = 1'b1, cfg_hi = 1'b0, flip = 1'b0, lfps = 1'b0, lowp = 1'b0, fsm_cm = 1'b0;
	logic [4:0] lane_cnt = 5'h00;
	logic [1:0] ds_st, us_st;
	logic [3:0] lane_en, eq1, eq2, equp;
	logic p1, n2, p2, n1, lp_exit, det, f_dn, f_up, cm_flag;
	int mreg [int];
	int wmask [int] = '{8'h13: 8'hbf, 8'h20: 8'hff, 8'h21: 8'h0f, 8'h22: 8'h7f};
	int regs [5] = '{8'h13, 8'h20, 8'h21, 8'h22, 8'h30};
	int det_sim [4] = '{20, 30, 40, 50};
	int err_count = 0;
	int num_checks = 0;

	always #12.5 ref_clk = ~ref_clk;
	// open-drain data wire with pull-up, device side drives its own low level
	assign sda = m_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);

	rdl_lane_regs #(.EXIT_DEB_CYC(16), .DET0_CYC(20), .DET1_CYC(30), .DET2_CYC(40),
		.DET3_CYC(50)) i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .eq_software_override_i(eq_ovr),
		.lane_config_high_bit_i(cfg_hi), .orientation_flip_select_i(flip),
		.snooped_lane_count_i(lane_cnt), .downstream_eq_straps_i(ds_st),
		.upstream_eq_straps_i(us_st), .lfps_detect_i(lfps), .low_power_state_i(lowp),
		.fsm_compliance_i(fsm_cm), .aux_p_sb1_o(p1), .aux_n_sb2_o(n2), .aux_p_sb2_o(p2),
		.aux_n_sb1_o(n1), .lane_enable_o(lane_en), .rx_one_eq_o(eq1), .rx_two_eq_o(eq2),
		.upstream_eq_o(equp), .low_power_exit_o(lp_exit), .rx_detect_pulse_o(det),
		.compliance_force_down_o(f_dn), .compliance_force_up_o(f_up),
		.compliance_active_flag_o(cm_flag));

	rdl_bus_master i_master (.ref_clk_i(ref_clk), .scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));

	// reference model of the register file
	function automatic int cm_exp(input int cc);
		return (cc == 0) ? fsm_cm : ((cc == 3) ? 0 : 1);
	endfunction
	function automatic int exp_reg(input int a);
		case (a)
			8'h13: return mreg[8'h13];
			8'h20: return eq_ovr ? mreg[8'h20] : ds_st * 17;
			8'h21: return eq_ovr ? mreg[8'h21] : us_st;
			8'h22: return mreg[8'h22] | (cm_exp(mreg[8'h22] & 3) << 7);
			default: return 0;
		endcase
	endfunction
	function automatic int lane_mask(input int c);
		return (c >= 4) ? 15 : (1 << c) - 1;
	endfunction
	function automatic int sw_exp(input int code, input int hi, input int fl);
		if (code == 1) return SW_STRAIGHT;
		if (code == 2) return SW_CROSSED;
		if (code == 3 || hi == 0) return SW_OPEN;
		return fl ? SW_CROSSED : SW_STRAIGHT;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input int exp, input string what);
		num_checks++;
		if (got !== exp[7:0]) begin
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp[7:0]);
			err_count++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_master.write_reg(a, d);
		if (wmask.exists(a)) mreg[a] = d & wmask[a];
		tick(3);
	endtask
	task automatic rd(input logic [7:0] a);
		logic [7:0] v;
		i_master.read_reg(a, v);
		chk(v, exp_reg(a), "register read");
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		foreach (wmask[k]) mreg[k] = 0;
		tick(8);
	endtask
	// count clocks up to the next detect pulse, sampled mid-cycle
	task automatic wait_det(output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (det !== 1'b1 && n < 300);
		if (n >= 300) begin
			chk(8'h00, 1, "detect pulse timeout");
			report_and_stop();
		end
		@(posedge ref_clk);
	endtask

	initial begin
		logic [7:0] d;
		int n;
		void'($urandom(32'h55a1));
		ds_st <= 2'($urandom);
		us_st <= 2'($urandom);
		do_reset();
		foreach (regs[i]) rd(regs[i][7:0]);
		eq_ovr <= 1'b0;
		tick(3);
		rd(8'h20);
		rd(8'h21);
		chk({eq2, eq1}, ds_st * 17, "strap eq");
		chk({4'h0, equp}, us_st, "strap upstream eq");
		$display("test reset_and_straps done");

		// snooping on: written lane bits ignored
		wr(8'h13, 8'h0f);
		for (int c = 0; c <= 5; c++) begin
			lane_cnt <= 5'(c);
			tick(4);
			chk({4'h0, lane_en}, lane_mask(c), "snooped lanes");
		end
		for (int k = 0; k < 3; k++) begin
			d = 8'($urandom) | 8'h80;
			wr(8'h13, d);
			lane_cnt <= 5'($urandom);
			tick(4);
			chk({4'h0, lane_en}, ~d & 15, "register lanes");
			rd(8'h13);
		end
		wr(8'h13, 8'h00);
		chk({4'h0, lane_en}, lane_mask(lane_cnt), "snoop back on");
		$display("test lanes done");

		for (int code = 0; code < 4; code++) begin
			wr(8'h13, 8'(code << 4));
			for (int k = 0; k < 4; k++) begin
				cfg_hi <= k[1];
				flip <= k[0];
				tick(3);
				chk({4'h0, p1, n2, p2, n1}, sw_exp(code, k[1], k[0]), "route");
			end
		end
		$display("test routing done");

		eq_ovr <= 1'b1;
		d = 8'($urandom);
		wr(8'h20, d);
		wr(8'h21, 8'hf0 | d);
		chk({eq2, eq1}, d, "software eq");
		chk({4'h0, equp}, d[3:0], "software upstream eq");
		rd(8'h20);
		rd(8'h21);
		lfps <= 1'b1;
		tick(5);
		chk({eq2, eq1}, 0, "eq during lfps");
		chk({4'h0, equp}, 0, "upstream eq during lfps");
		wr(8'h22, 8'h40);
		chk({eq2, eq1}, d, "eq applied in lfps");
		lfps <= 1'b0;
		tick(4);
		chk({4'h0, equp}, d[3:0], "upstream eq after lfps");
		$display("test equalization done");

		lowp <= 1'b1;
		lfps <= 1'b1;
		tick(8);
		chk({7'h0, lp_exit}, 1, "exit without debounce");
		lfps <= 1'b0;
		tick(6);
		wr(8'h22, 8'h20);
		lfps <= 1'b1;
		tick(10);
		chk({7'h0, lp_exit}, 0, "exit too early");
		tick(16);
		chk({7'h0, lp_exit}, 1, "exit after debounce");
		lfps <= 1'b0;
		lowp <= 1'b0;
		$display("test debounce done");

		for (int code = 0; code < 4; code++) begin
			wr(8'h22, 8'(code << 2));
			wait_det(n);
			wait_det(n);
			chk(8'(n), det_sim[code], "detect interval");
		end
		wr(8'h22, 8'h10);
		lowp <= 1'b1;
		tick(5);
		n = 0;
		repeat (120) begin
			@(negedge ref_clk);
			if (det === 1'b1) n++;
		end
		@(posedge ref_clk);
		chk(8'(n), 0, "detect in low power");
		lowp <= 1'b0;
		$display("test detect done");

		fsm_cm <= 1'b1;
		for (int code = 0; code < 4; code++) begin
			wr(8'h22, 8'h80 | 8'(code));
			chk({6'h0, f_dn, f_up}, (code == 1) ? 2 : ((code == 2) ? 1 : 0), "forcing");
			chk({7'h0, cm_flag}, cm_exp(code), "compliance flag");
			rd(8'h22);
		end
		$display("test compliance done");

		wr(8'h30, 8'hff);
		foreach (regs[i]) rd(regs[i][7:0]);
		do_reset();
		foreach (regs[i]) rd(regs[i][7:0]);
		chk(8'(i_master.nack_count), 0, "missing acknowledge");
		$display("test unmapped_and_reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
